// ==== rtl/uart_chan_consts.svh ====
// Offsets, bit positions, reset values and codes of one UART channel
`ifndef UART_CHAN_CONSTS_SVH
`define UART_CHAN_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses on A2..A0
// ----------------------------------------------------------------
`define ADDR_DATA 3'h0
`define ADDR_IER 3'h1
`define ADDR_ISR 3'h2
`define ADDR_LCR 3'h3
`define ADDR_MCR 3'h4
`define ADDR_LSR 3'h5
`define ADDR_MSR 3'h6
`define ADDR_SPR 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LCR_DIVISOR_BIT 7
`define LCR_BREAK_BIT 6
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_OUT1_BIT 2
`define MCR_INT_EN_BIT 3
`define MCR_LOOP_BIT 4
`define IER_RX_BIT 0
`define IER_THR_BIT 1
`define IER_LINE_BIT 2
`define IER_MODEM_BIT 3
`define LSR_DATA_READY_BIT 0
`define LSR_OVERRUN_BIT 1
`define LSR_PARITY_BIT 2
`define LSR_FRAMING_BIT 3
`define LSR_BREAK_BIT 4
`define LSR_THR_EMPTY_BIT 5
`define LSR_TX_IDLE_BIT 6
`define LSR_FIFO_ERR_BIT 7
`define FCR_FIFO_EN_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_IER 8'h00
`define RST_FCR 8'h00
`define RST_LCR 8'h00
`define RST_MCR 8'h00
`define RST_LSR 8'h60
`define RST_SPR 8'hFF
`define RST_MSR_DELTA 4'h0

// ----------------------------------------------------------------
// Interrupt source codes, highest priority first
// ----------------------------------------------------------------
`define ISR_LINE 4'h6
`define ISR_RX 4'h4
`define ISR_THR 4'h2
`define ISR_MODEM 4'h0
`define ISR_NONE 4'h1

`endif

// ==== rtl/uart_chan_pkg.sv ====
// Types shared by the UART channel register bank
package uart_chan_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_type;

    // Pins from the host bus and modem, all asynchronous
    typedef struct packed {
        logic cs_n;
        logic read_n;
        logic write_n;
        logic [2:0] addr;
        logic [7:0] data;
        logic mode_intel;
        logic irq_select_in;
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic cd_n;
    } pins_type;

    // Events and line levels from the serial datapath, same clock
    typedef struct packed {
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_parity_err;
        logic rx_framing_err;
        logic rx_break;
        logic thr_taken;
        logic tx_idle;
        logic tx_bit;
        logic ir_bit;
    } xfer_in_type;

    // Configuration handed to the serial datapath
    typedef struct packed {
        logic [15:0] divisor;
        logic [7:0] line_control;
        logic [7:0] fifo_control;
        logic [7:0] interrupt_enable;
        logic [7:0] modem_control;
    } cfg_type;

endpackage

// ==== rtl/uart_chan_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
module uart_chan_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // No reset: pure pipeline, settles within two edges of reset
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end

    assign o_sync = sync_q;
endmodule

// ==== rtl/uart_chan_regs.sv ====
// Register bank, reset state and pin levels of one UART channel
//
// Overview of operation
// - Scratch byte stores host byte, nothing else
// - Divisor is low byte then high byte
// - Divisor halves untouched by reset
// - Reset clears enable, fifo, line, modem control
// - Reset interrupt source reads 0x01
// - Reset line state reads 0x60
// - Reset clears deltas; upper shows inverted inputs
// - Reset loads scratch byte with 0xFF
// - Holding registers are not reset
// - Reset drives RTS and DTR high
// - Reset: receive ready high, transmit ready low
// - Reset: interrupt low, shared request high
// - Divisor reached only while line control bit7
// - Transmitter idle flag follows holding and shifter
`timescale 1ns/100ps
`include "uart_chan_consts.svh"
module uart_chan_regs (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire uart_chan_pkg::pins_type i_pins,
    input wire uart_chan_pkg::xfer_in_type i_xfer,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output uart_chan_pkg::cfg_type o_cfg,
    output logic [7:0] o_tx_byte,
    output logic o_tx_load,
    output logic o_tx,
    output logic o_infrared_transmit_out,
    output logic o_rts_n,
    output logic o_dtr_n,
    output logic o_receive_ready_n,
    output logic o_transmit_ready_n,
    output logic o_int,
    output logic o_int_oe,
    output logic o_irq_n
);
    import uart_chan_pkg::*;

    // ------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------
    typedef struct packed {
        bus_state_type bus;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [15:0] divisor;
        logic [7:0] receive_holding;
        logic [7:0] transmit_holding;
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] line_state;
        logic [7:0] scratch_byte;
        logic [3:0] modem_delta;
        logic [3:0] modem_prev;
        logic tx_load;
        logic tx_out;
        logic infrared_transmit_out_out;
    } state_type;

    state_type s_q;
    state_type s_d;
    pins_type pins_s;
    logic rd_active;
    logic wr_active;
    logic dlab;
    logic loopback;
    logic [3:0] modem_now;
    logic [3:0] isr_code;
    logic [7:0] isr_byte;
    logic pending;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    // Data and address bits may skew by a cycle; the host holds them
    // stable across the strobe, and writes commit on strobe release.
    uart_chan_sync #(
        .WIDTH($bits(pins_type))
    ) u_sync (
        .i_clk(i_clk),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    // ------------------------------------------------------------
    // Decode and derived status
    // ------------------------------------------------------------
    always_comb begin
        if (pins_s.mode_intel) begin
            rd_active = !pins_s.cs_n && !pins_s.read_n;
            wr_active = !pins_s.cs_n && !pins_s.write_n && pins_s.read_n;
        end else begin
            // Motorola style: one line carries read high, write low
            rd_active = !pins_s.cs_n && pins_s.write_n;
            wr_active = !pins_s.cs_n && !pins_s.write_n;
        end
    end

    assign dlab = s_q.line_control[`LCR_DIVISOR_BIT];
    assign loopback = s_q.modem_control[`MCR_LOOP_BIT];

    // Status bits 7..4 as CD, RI, DSR, CTS
    always_comb begin
        if (loopback) begin
            modem_now = {s_q.modem_control[`MCR_INT_EN_BIT],
                         s_q.modem_control[`MCR_OUT1_BIT],
                         s_q.modem_control[`MCR_DTR_BIT],
                         s_q.modem_control[`MCR_RTS_BIT]};
        end else begin
            modem_now = {~pins_s.cd_n, ~pins_s.ri_n, ~pins_s.dsr_n, ~pins_s.cts_n};
        end
    end

    always_comb begin
        if (s_q.interrupt_enable[`IER_LINE_BIT] &&
            (|s_q.line_state[`LSR_BREAK_BIT:`LSR_OVERRUN_BIT])) begin
            isr_code = `ISR_LINE;
        end else if (s_q.interrupt_enable[`IER_RX_BIT] &&
                     s_q.line_state[`LSR_DATA_READY_BIT]) begin
            isr_code = `ISR_RX;
        end else if (s_q.interrupt_enable[`IER_THR_BIT] &&
                     s_q.line_state[`LSR_THR_EMPTY_BIT]) begin
            isr_code = `ISR_THR;
        end else if (s_q.interrupt_enable[`IER_MODEM_BIT] && (|s_q.modem_delta)) begin
            isr_code = `ISR_MODEM;
        end else begin
            isr_code = `ISR_NONE;
        end
    end

    assign isr_byte = {{2{s_q.fifo_control[`FCR_FIFO_EN_BIT]}}, 2'b00, isr_code};
    assign pending = !isr_code[0];

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    function automatic logic [7:0] read_value(input logic [2:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `ADDR_DATA: v = dlab ? s_q.divisor[7:0] : s_q.receive_holding;
            `ADDR_IER: v = dlab ? s_q.divisor[15:8] : s_q.interrupt_enable;
            `ADDR_ISR: v = isr_byte;
            `ADDR_LCR: v = s_q.line_control;
            `ADDR_MCR: v = s_q.modem_control;
            `ADDR_LSR: v = s_q.line_state;
            `ADDR_MSR: v = {modem_now, s_q.modem_delta};
            `ADDR_SPR: v = s_q.scratch_byte;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.tx_load = 1'b0;

        // Host clears happen first so that datapath sets win below, except that a holding load beats thr_taken
        case (s_q.bus)
            BUS_IDLE: begin
                if (rd_active) begin
                    s_d.bus = BUS_READ;
                    s_d.addr = pins_s.addr;
                    s_d.rdata = read_value(pins_s.addr);
                    case (pins_s.addr)
                        `ADDR_DATA: begin
                            if (!dlab) begin
                                s_d.line_state[`LSR_DATA_READY_BIT] = 1'b0;
                            end
                        end
                        `ADDR_LSR: begin
                            s_d.line_state[`LSR_BREAK_BIT:`LSR_OVERRUN_BIT] = 4'h0;
                            s_d.line_state[`LSR_FIFO_ERR_BIT] = 1'b0;
                        end
                        `ADDR_MSR: s_d.modem_delta = 4'h0;
                        default: s_d.bus = BUS_READ;
                    endcase
                end else if (wr_active) begin
                    s_d.bus = BUS_WRITE;
                    s_d.addr = pins_s.addr;
                    s_d.wdata = pins_s.data;
                end
            end
            BUS_READ: begin
                if (!rd_active) begin
                    s_d.bus = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (wr_active) begin
                    s_d.addr = pins_s.addr;
                    s_d.wdata = pins_s.data;
                end else begin
                    // Commit on strobe release, with data seen while it was active
                    s_d.bus = BUS_IDLE;
                    case (s_q.addr)
                        `ADDR_DATA: begin
                            if (dlab) begin
                                s_d.divisor[7:0] = s_q.wdata;
                            end else begin
                                s_d.transmit_holding = s_q.wdata;
                                s_d.tx_load = 1'b1;
                                s_d.line_state[`LSR_THR_EMPTY_BIT] = 1'b0;
                            end
                        end
                        `ADDR_IER: begin
                            if (dlab) begin
                                s_d.divisor[15:8] = s_q.wdata;
                            end else begin
                                s_d.interrupt_enable = s_q.wdata;
                            end
                        end
                        `ADDR_ISR: s_d.fifo_control = s_q.wdata;
                        `ADDR_LCR: s_d.line_control = s_q.wdata;
                        `ADDR_MCR: s_d.modem_control = s_q.wdata;
                        `ADDR_LSR: s_d.line_state = s_q.wdata;
                        `ADDR_MSR: s_d.modem_delta = s_q.wdata[3:0];
                        `ADDR_SPR: s_d.scratch_byte = s_q.wdata;
                        default: s_d.bus = BUS_IDLE;
                    endcase
                end
            end
            default: s_d.bus = BUS_IDLE;
        endcase

        // Datapath events
        if (i_xfer.thr_taken && !s_d.tx_load) begin
            s_d.line_state[`LSR_THR_EMPTY_BIT] = 1'b1;
        end
        if (i_xfer.rx_valid) begin
            s_d.receive_holding = i_xfer.rx_data;
            if (s_q.line_state[`LSR_DATA_READY_BIT]) begin
                // Unread byte overwritten
                s_d.line_state[`LSR_OVERRUN_BIT] = 1'b1;
            end
            s_d.line_state[`LSR_DATA_READY_BIT] = 1'b1;
            s_d.line_state[`LSR_PARITY_BIT] = i_xfer.rx_parity_err;
            s_d.line_state[`LSR_FRAMING_BIT] = i_xfer.rx_framing_err;
            s_d.line_state[`LSR_BREAK_BIT] = i_xfer.rx_break;
            if (i_xfer.rx_parity_err || i_xfer.rx_framing_err || i_xfer.rx_break) begin
                s_d.line_state[`LSR_FIFO_ERR_BIT] = 1'b1;
            end
        end
        s_d.line_state[`LSR_TX_IDLE_BIT] =
            s_d.line_state[`LSR_THR_EMPTY_BIT] && i_xfer.tx_idle;

        // Modem change detection; RI flags only its trailing edge
        s_d.modem_delta[0] = s_d.modem_delta[0] | (modem_now[0] ^ s_q.modem_prev[0]);
        s_d.modem_delta[1] = s_d.modem_delta[1] | (modem_now[1] ^ s_q.modem_prev[1]);
        s_d.modem_delta[2] = s_d.modem_delta[2] | (s_q.modem_prev[2] & ~modem_now[2]);
        s_d.modem_delta[3] = s_d.modem_delta[3] | (modem_now[3] ^ s_q.modem_prev[3]);
        s_d.modem_prev = modem_now;

        s_d.tx_out = s_q.line_control[`LCR_BREAK_BIT] ? 1'b0 : i_xfer.tx_bit;
        s_d.infrared_transmit_out_out = i_xfer.ir_bit;

        // Synchronous reset; divisor and holding registers keep their value
        if (!i_resetn) begin
            s_d.bus = BUS_IDLE;
            s_d.addr = 3'h0;
            s_d.wdata = 8'h00;
            s_d.rdata = 8'h00;
            s_d.divisor = s_q.divisor;
            s_d.receive_holding = s_q.receive_holding;
            s_d.transmit_holding = s_q.transmit_holding;
            s_d.interrupt_enable = `RST_IER;
            s_d.fifo_control = `RST_FCR;
            s_d.line_control = `RST_LCR;
            s_d.modem_control = `RST_MCR;
            s_d.line_state = `RST_LSR;
            s_d.scratch_byte = `RST_SPR;
            s_d.modem_delta = `RST_MSR_DELTA;
            s_d.modem_prev = {~pins_s.cd_n, ~pins_s.ri_n, ~pins_s.dsr_n, ~pins_s.cts_n};
            s_d.tx_load = 1'b0;
            s_d.tx_out = 1'b1;
            s_d.infrared_transmit_out_out = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_data = s_q.rdata;
    assign o_data_oe = (s_q.bus == BUS_READ);
    assign o_cfg = '{divisor: s_q.divisor,
                     line_control: s_q.line_control,
                     fifo_control: s_q.fifo_control,
                     interrupt_enable: s_q.interrupt_enable,
                     modem_control: s_q.modem_control};
    assign o_tx_byte = s_q.transmit_holding;
    assign o_tx_load = s_q.tx_load;
    assign o_tx = s_q.tx_out;
    assign o_infrared_transmit_out = s_q.infrared_transmit_out_out;
    // Loopback keeps the modem outputs inactive on the pins
    assign o_rts_n = !(s_q.modem_control[`MCR_RTS_BIT] && !loopback);
    assign o_dtr_n = !(s_q.modem_control[`MCR_DTR_BIT] && !loopback);
    assign o_receive_ready_n = !s_q.line_state[`LSR_DATA_READY_BIT];
    assign o_transmit_ready_n = !s_q.line_state[`LSR_THR_EMPTY_BIT];
    assign o_int = pending && pins_s.mode_intel;
    assign o_int_oe = pins_s.mode_intel &&
                      (pins_s.irq_select_in || s_q.modem_control[`MCR_INT_EN_BIT]);
    assign o_irq_n = !(pending && !pins_s.mode_intel);
endmodule

// ==== verif/uart_chan_regs_asserts.sv ====
// Concurrent checks on the reset state and pin levels of one UART channel
`timescale 1ns/100ps
module uart_chan_regs_asserts (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire uart_chan_pkg::cfg_type o_cfg,
    input wire logic o_tx_load,
    input wire logic o_tx,
    input wire logic o_infrared_transmit_out,
    input wire logic o_rts_n,
    input wire logic o_dtr_n,
    input wire logic o_receive_ready_n,
    input wire logic o_transmit_ready_n,
    input wire logic o_int,
    input wire logic o_irq_n,
    input wire logic o_data_oe
);
    import uart_chan_pkg::*;
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking

    sequence in_reset;
        !i_resetn;
    endsequence

    // Break must have been seen on two edges before the pin follows
    sequence break_held;
        o_cfg.line_control[6] ##1 o_cfg.line_control[6];
    endsequence

    reset_ctrl_a: assert property (
        in_reset |=> o_cfg.interrupt_enable == 8'h00 && o_cfg.fifo_control == 8'h00
            && o_cfg.line_control == 8'h00 && o_cfg.modem_control == 8'h00)
        else $error("control byte not cleared by reset");
    reset_serial_a: assert property (in_reset |=> o_tx && !o_infrared_transmit_out)
        else $error("serial pins wrong in reset");
    reset_modem_a: assert property (in_reset |=> o_rts_n && o_dtr_n)
        else $error("modem outputs wrong in reset");
    reset_ready_a: assert property (in_reset |=> o_receive_ready_n && !o_transmit_ready_n)
        else $error("ready outputs wrong in reset");
    reset_irq_a: assert property (in_reset |=> !o_int && o_irq_n)
        else $error("interrupt outputs wrong in reset");
    reset_quiet_a: assert property (in_reset |=> !o_tx_load && !o_data_oe)
        else $error("bus activity during reset");
    divisor_keep_a: assert property (in_reset |=> o_cfg.divisor === $past(o_cfg.divisor))
        else $error("divisor disturbed by reset");
    sync_reset_a: assert property (
        $past(i_resetn) && !i_resetn |-> o_cfg.modem_control == $past(o_cfg.modem_control))
        else $error("reset acted before the clock edge");
    divisor_gate_a: assert property (disable iff (!i_resetn)
        o_cfg.divisor !== $past(o_cfg.divisor) |-> $past(o_cfg.line_control[7]))
        else $error("divisor written with access bit clear");
    load_busy_a: assert property (disable iff (!i_resetn)
        o_tx_load |-> o_transmit_ready_n ##1 !o_tx_load)
        else $error("holding load left empty flag set");
    break_low_a: assert property (disable iff (!i_resetn) break_held |-> !o_tx)
        else $error("break not driven on serial out");
endmodule

bind uart_chan_regs uart_chan_regs_asserts i_uart_chan_regs_asserts (
    .i_clk(i_clk), .i_resetn(i_resetn), .o_cfg(o_cfg), .o_tx_load(o_tx_load),
    .o_tx(o_tx), .o_infrared_transmit_out(o_infrared_transmit_out), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n),
    .o_receive_ready_n(o_receive_ready_n), .o_transmit_ready_n(o_transmit_ready_n),
    .o_int(o_int), .o_irq_n(o_irq_n), .o_data_oe(o_data_oe)
);

// ==== verif/host_bus_model.sv ====
// Host processor model on the Intel-style 8-bit register bus
`timescale 1ns/100ps
module host_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    output logic o_cs_n,
    output logic o_read_n,
    output logic o_write_n,
    output logic [2:0] o_addr,
    output logic [7:0] o_data
);
    // Strobe length in cycles; raised to play a slow host
    int strobe_cycles = 4;

    initial begin
        o_cs_n = 1'b1;
        o_read_n = 1'b1;
        o_write_n = 1'b1;
        o_addr = 3'h0;
        o_data = 8'h00;
    end

    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] rd);
        @(negedge i_clk);
        o_addr = a;
        o_data = wr ? d : ~o_data;
        o_cs_n = 1'b0;
        o_read_n = wr;
        o_write_n = !wr;
        repeat (strobe_cycles) @(posedge i_clk);
        @(negedge i_clk);
        rd = (i_data_oe === 1'b1) ? i_data : 8'hXX;
        o_cs_n = 1'b1;
        o_read_n = 1'b1;
        o_write_n = 1'b1;
        // Address and data held past the commit, then shown as released
        repeat (4) @(negedge i_clk);
        o_addr = ~a;
        o_data = ~o_data;
    endtask
endmodule

// ==== verif/tb_uart_channel_reset_and_divisor.sv ====
// Self-checking bench for the reset state and divisor of one UART channel
`timescale 1ns/100ps
module tb_uart_channel_reset_and_divisor;
    import uart_chan_pkg::*;
    logic i_clk, i_resetn, cs_n, read_n, write_n, mode_intel, irq_sel;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, tx_byte;
    logic [3:0] modem_n;
    pins_type pins;
    xfer_in_type xfer;
    cfg_type cfg, cfg_before;
    logic data_oe, tx_load, tx, infrared_transmit_out, rts_n, dtr_n, rx_rdy_n, tx_rdy_n, int_o, int_oe, irq_n;
    int failures = 0;
    int total_checks = 0;
    logic [2:0] rst_addr [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0] rst_val [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h50, 8'hFF};

    // Modem inputs in order cts, dsr, ri, cd
    assign pins = {cs_n, read_n, write_n, addr, wdata, mode_intel, irq_sel, modem_n};

    uart_chan_regs i_uart_chan_regs (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_pins(pins), .i_xfer(xfer),
        .o_data(rdata), .o_data_oe(data_oe), .o_cfg(cfg), .o_tx_byte(tx_byte),
        .o_tx_load(tx_load), .o_tx(tx), .o_infrared_transmit_out(infrared_transmit_out), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
        .o_receive_ready_n(rx_rdy_n), .o_transmit_ready_n(tx_rdy_n), .o_int(int_o),
        .o_int_oe(int_oe), .o_irq_n(irq_n)
    );

    host_bus_model i_host_bus_model (
        .i_clk(i_clk), .i_data(rdata), .i_data_oe(data_oe), .o_cs_n(cs_n),
        .o_read_n(read_n), .o_write_n(write_n), .o_addr(addr), .o_data(wdata)
    );

    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_host_bus_model.access(1'b1, a, d, unused);
    endtask

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_host_bus_model.access(1'b0, a, 8'h00, got);
        check_val(what, 16'(exp), 16'(got));
    endtask

    task automatic pulse_xfer(input logic rx, input logic taken);
        @(negedge i_clk);
        xfer.rx_valid = rx;
        xfer.thr_taken = taken;
        @(negedge i_clk);
        xfer.rx_valid = 1'b0;
        xfer.thr_taken = 1'b0;
    endtask

    // Reset is entered in the bus mode that routes the shared request
    task automatic reset_and_check();
        @(negedge i_clk);
        i_resetn = 1'b0;
        mode_intel = 1'b0;
        repeat (5) @(negedge i_clk);
        check_bit("tx", 1'b1, tx);
        check_bit("infrared_transmit_out", 1'b0, infrared_transmit_out);
        check_bit("rts_n", 1'b1, rts_n);
        check_bit("dtr_n", 1'b1, dtr_n);
        check_bit("receive_ready_n", 1'b1, rx_rdy_n);
        check_bit("transmit_ready_n", 1'b0, tx_rdy_n);
        check_bit("irq_n", 1'b1, irq_n);
        mode_intel = 1'b1;
        repeat (3) @(negedge i_clk);
        check_bit("int", 1'b0, int_o);
        check_bit("int_oe", 1'b0, int_oe);
        i_resetn = 1'b1;
        for (int k = 0; k < 7; k++) begin
            rd_chk("reset value", rst_addr[k], rst_val[k]);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever begin
            #25 i_clk = ~i_clk;
        end
    end

    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        end_of_test();
    end

    initial begin
        i_resetn = 1'b0;
        mode_intel = 1'b1;
        irq_sel = 1'b0;
        modem_n = 4'b0101;
        xfer = '0;
        xfer.tx_idle = 1'b1;
        xfer.tx_bit = 1'b1;
        reset_and_check();
        $display("test reset_values done");
        cfg_before = cfg;
        wr(3'h7, 8'h5A);
        rd_chk("scratch", 3'h7, 8'h5A);
        check_bit("config untouched", 1'b1, cfg === cfg_before);
        i_host_bus_model.strobe_cycles = 7;
        wr(3'h7, 8'h00);
        rd_chk("scratch slow", 3'h7, 8'h00);
        i_host_bus_model.strobe_cycles = 4;
        $display("test scratch done");
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        check_val("divisor", 16'h1234, cfg.divisor);
        rd_chk("divisor low", 3'h0, 8'h34);
        rd_chk("divisor high", 3'h1, 8'h12);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h05);
        rd_chk("enable", 3'h1, 8'h05);
        check_val("divisor kept", 16'h1234, cfg.divisor);
        $display("test divisor done");
        xfer.tx_idle = 1'b0;
        wr(3'h0, 8'hC3);
        check_val("tx byte", 16'h00C3, 16'(tx_byte));
        check_bit("transmit_ready_n", 1'b1, tx_rdy_n);
        rd_chk("line state full", 3'h5, 8'h00);
        pulse_xfer(1'b0, 1'b1);
        rd_chk("line state shifting", 3'h5, 8'h20);
        xfer.tx_idle = 1'b1;
        rd_chk("line state idle", 3'h5, 8'h60);
        xfer.rx_data = 8'hA5;
        pulse_xfer(1'b1, 1'b0);
        check_bit("receive_ready_n", 1'b0, rx_rdy_n);
        rd_chk("receive byte", 3'h0, 8'hA5);
        check_bit("receive_ready_n read", 1'b1, rx_rdy_n);
        $display("test holding done");
        modem_n = 4'b1010;
        rst_val[5] = 8'hA0;
        wr(3'h4, 8'h03);
        wr(3'h7, 8'h3C);
        wr(3'h3, 8'h43);
        xfer.tx_bit = 1'b0;
        xfer.ir_bit = 1'b1;
        repeat (3) @(negedge i_clk);
        check_bit("rts_n on", 1'b0, rts_n);
        check_bit("dtr_n on", 1'b0, dtr_n);
        reset_and_check();
        check_val("divisor after reset", 16'h1234, cfg.divisor);
        wr(3'h3, 8'h80);
        rd_chk("divisor low after reset", 3'h0, 8'h34);
        rd_chk("divisor high after reset", 3'h1, 8'h12);
        $display("test mid_run_reset done");
        end_of_test();
    end
endmodule
